// ===== verilog/slp_ctrl.sv
// Sleep controller: sleeps on the core's sleep strobe when armed, gates clock domains
// and oscillators, wakes on qualified sources. Assumes all inputs are
// synchronous to mclk and that wake sources are pre-enabled upstream.
`timescale 1ns/1ps
`default_nettype none
`include "slp_defines.svh"
module slp_ctrl
   import slp_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = `SLP_STARTUP_CYC,
   parameter int unsigned BOD_WAKE_CYC = `SLP_BOD_WAKE_CYC
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ctrlWrEn,
   input wire logic [7:0] ctrlWrData,
   input wire logic mcuWrEn,
   input wire logic [7:0] mcuWrData,
   input wire logic sleepInstr,
   input wire logic extCrystal,
   input wire logic adcEnabled,
   input wire logic t2Enabled,
   input wire logic t2Async,
   input wire logic t2SyncClk,
   input wire logic globalIrqEn,
   input wire logic [1:0] t2IrqMask,
   input wire logic [1:0] t2Event,
   input wire logic extLevelIrq,
   input wire logic pinChangeIrq,
   input wire logic twoWireMatch,
   input wire logic watchdogIrq,
   input wire logic adcDoneIrq,
   input wire logic selfProgReady,
   input wire logic otherIoIrq,
   input wire logic wakeReset,
   output logic [7:0] sleepCtrlRd,
   output logic [7:0] mcuCtrlRd,
   output logic cpuClkEn,
   output logic flashClkEn,
   output logic ioClkEn,
   output logic adcClkEn,
   output logic asyClkEn,
   output logic mainOscEn,
   output logic timerOscEn,
   output logic bodEn,
   output logic adcStart,
   output logic coreHalt,
   output logic irqDeliver,
   output logic resetVector,
   output logic sleeping
);

   typedef struct packed {
      slp_state_t st;
      logic [2:0] mode;
      logic arm;
      logic brownout_sleep_off;
      logic bodse;
      logic [2:0] seWin;
      logic bodOff;
      logic fromReset;
      logic levelWake;
      logic [15:0] cnt;
      logic [7:0] sleepCtrlRd;
      logic [7:0] mcuCtrlRd;
      logic [7:0] clk;
      logic adcStart;
      logic coreHalt;
      logic irqDeliver;
      logic resetVector;
      logic sleeping;
   } slp_ctrl_t;

   slp_ctrl_t cur_ff;
   slp_ctrl_t nxt_cur;
   slp_mode_t mode;
   logic deep;
   logic wakeAny;
   logic baseWake;
   logic irqWake;

   assign mode = slp_mode_t'(cur_ff.mode);
   // Modes where software brown-out disable is honoured
   assign deep = (mode == SLP_PDOWN) || (mode == SLP_PSAVE) ||
                 (mode == SLP_STBY) || (mode == SLP_XSTBY); // RL9

   // ---------------------------------------------------------------
   // Wake qualification per mode
   // ---------------------------------------------------------------
   always_comb
   begin
      // Asynchronous sources wake every mode
      baseWake = extLevelIrq || pinChangeIrq || twoWireMatch || watchdogIrq;
      case (mode)
         SLP_ADCNR:
            irqWake = baseWake || adcDoneIrq || selfProgReady ||
                      (t2Async && |t2Event); // RL13
         SLP_PDOWN, SLP_STBY:
            irqWake = baseWake; // RL15
         SLP_PSAVE, SLP_XSTBY:
            irqWake = baseWake || (globalIrqEn && |(t2Event & t2IrqMask)); // RL18 RL19
         default:
            irqWake = baseWake || adcDoneIrq || selfProgReady || otherIoIrq ||
                      |t2Event; // RL10 RL24
      endcase
      wakeAny = irqWake || wakeReset;
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.adcStart = 1'b0;
      nxt_cur.irqDeliver = 1'b0;
      nxt_cur.resetVector = 1'b0;
      if (cur_ff.seWin != 3'h0)
      begin
         nxt_cur.seWin = cur_ff.seWin - 3'h1;
      end
      if (nxt_cur.seWin == 3'h0)
      begin
         nxt_cur.bodse = 1'b0;
      end
      if (ctrlWrEn)
      begin
         nxt_cur.arm = ctrlWrData[`SLP_SE_BIT]; // RL23
         nxt_cur.mode = ctrlWrData[`SLP_SM_MSB:`SLP_SM_LSB];
      end
      if (mcuWrEn)
      begin
         // Timed sequence: enable and bit together, then bit alone in window
         if (mcuWrData[`SLP_BROWNOUT_SLEEP_OFF_BIT] && mcuWrData[`SLP_BODSE_BIT])
         begin
            nxt_cur.bodse = 1'b1;
            nxt_cur.seWin = 3'(`SLP_BODSE_WIN); // RL8
         end
         else if (cur_ff.bodse)
         begin
            nxt_cur.brownout_sleep_off = mcuWrData[`SLP_BROWNOUT_SLEEP_OFF_BIT]; // RL7 RL8
            nxt_cur.bodse = 1'b0;
            nxt_cur.seWin = 3'h0;
         end
      end
      case (cur_ff.st)
         ST_RUN:
         begin
            // Clock bits: cpu flash io adc asy main timer bod
            nxt_cur.clk = 8'hff;
            if (sleepInstr && cur_ff.arm) // RL1
            begin
               nxt_cur.st = ST_SLEEP;
               nxt_cur.sleeping = 1'b1;
               nxt_cur.coreHalt = 1'b1;
               nxt_cur.bodOff = 1'b0;
               case (mode)
                  SLP_ADCNR:
                  begin
                     nxt_cur.clk = {3'b000, 1'b1, 1'b1, 1'b1, t2Async, 1'b1}; // RL12
                     nxt_cur.adcStart = adcEnabled; // RL11
                  end
                  SLP_PDOWN:
                     nxt_cur.clk = 8'h01; // RL14
                  SLP_PSAVE:
                     nxt_cur.clk = {4'h0, t2Async, t2Enabled && t2SyncClk,
                                    t2Async, 1'b1}; // RL20
                  // Standby codes assume a crystal source; extCrystal is not checked
                  SLP_STBY:
                     nxt_cur.clk = 8'h05; // RL22
                  SLP_XSTBY:
                     nxt_cur.clk = {4'h0, t2Async, 1'b1, t2Async, 1'b1}; // RL22
                  default:
                  begin
                     nxt_cur.clk = {2'b00, 6'h3f}; // RL10 RL24
                     nxt_cur.adcStart = adcEnabled; // RL11
                  end
               endcase
               // Brown-out switched off right after entry when eligible
               if (cur_ff.brownout_sleep_off && deep)
               begin
                  nxt_cur.clk[0] = 1'b0; // RL5
                  nxt_cur.bodOff = 1'b1;
               end
            end
         end
         ST_SLEEP:
         begin
            if (wakeAny)
            begin
               nxt_cur.st = ST_START;
               nxt_cur.fromReset = wakeReset;
               nxt_cur.levelWake = irqWake;
               nxt_cur.clk[0] = 1'b1; // RL5
               if (cur_ff.bodOff)
               begin
                  nxt_cur.cnt = 16'(BOD_WAKE_CYC); // RL6
               end
               else if ((mode == SLP_PDOWN) || (mode == SLP_PSAVE))
               begin
                  nxt_cur.cnt = 16'(STARTUP_CYC); // RL17
               end
               else if ((mode == SLP_STBY) || (mode == SLP_XSTBY))
               begin
                  nxt_cur.cnt = 16'(`SLP_STBY_CYC); // RL22
               end
               else
               begin
                  nxt_cur.cnt = 16'h0001;
               end
               // Restart oscillators first so they settle during the count
               nxt_cur.clk[2] = 1'b1;
               nxt_cur.clk[1] = 1'b1;
            end
         end
         ST_START:
         begin
            if (cur_ff.cnt > 16'h0001)
            begin
               nxt_cur.cnt = cur_ff.cnt - 16'h0001;
            end
            else
            begin
               nxt_cur.clk = 8'hff; // RL25
               nxt_cur.bodOff = 1'b0;
               if (cur_ff.fromReset)
               begin
                  nxt_cur.st = ST_RUN;
                  nxt_cur.coreHalt = 1'b0;
                  nxt_cur.sleeping = 1'b0;
                  nxt_cur.resetVector = 1'b1; // RL4
                  nxt_cur.arm = 1'b0;
                  nxt_cur.mode = 3'h0;
                  nxt_cur.brownout_sleep_off = 1'b0;
               end
               else
               begin
                  nxt_cur.st = ST_HALT;
                  nxt_cur.cnt = 16'(`SLP_HALT_CYC); // RL2
                  // Level source must still be present at end of start-up
                  nxt_cur.levelWake = irqWake; // RL16
               end
            end
         end
         ST_HALT:
         begin
            if (cur_ff.cnt > 16'h0001)
            begin
               nxt_cur.cnt = cur_ff.cnt - 16'h0001;
            end
            else
            begin
               nxt_cur.st = ST_RUN;
               nxt_cur.coreHalt = 1'b0;
               nxt_cur.sleeping = 1'b0;
               nxt_cur.irqDeliver = cur_ff.levelWake; // RL2 RL16
            end
         end
         default:
            nxt_cur.st = ST_RUN;
      endcase
      // Register file and SRAM live outside; only clocks are gated, no clear
      nxt_cur.sleepCtrlRd = {4'h0, nxt_cur.mode, nxt_cur.arm}; // RL3 RL23
      nxt_cur.mcuCtrlRd = {1'b0, nxt_cur.brownout_sleep_off, nxt_cur.bodse, 5'h00};
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         cur_ff <= '0;
         cur_ff.st <= ST_RUN;
         cur_ff.clk <= 8'hff;
         cur_ff.sleepCtrlRd <= `SLP_CTRL_RST;
         cur_ff.mcuCtrlRd <= `SLP_MCU_RST;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   assign sleepCtrlRd = cur_ff.sleepCtrlRd;
   assign mcuCtrlRd = cur_ff.mcuCtrlRd;
   assign cpuClkEn = cur_ff.clk[7];
   assign flashClkEn = cur_ff.clk[6];
   assign ioClkEn = cur_ff.clk[5];
   assign adcClkEn = cur_ff.clk[4];
   assign asyClkEn = cur_ff.clk[3];
   assign mainOscEn = cur_ff.clk[2];
   assign timerOscEn = cur_ff.clk[1];
   assign bodEn = cur_ff.clk[0];
   assign adcStart = cur_ff.adcStart;
   assign coreHalt = cur_ff.coreHalt;
   assign irqDeliver = cur_ff.irqDeliver;
   assign resetVector = cur_ff.resetVector;
   assign sleeping = cur_ff.sleeping;

endmodule : slp_ctrl
`default_nettype wire

// ===== pkg/slp_defines.svh
// Constants for the sleep-mode clock gating controller.
// Assumes a 40 MHz mclk; included by the design file only, not by the package.
// Notes on behaviour
// RL1 - Software sets sleep arm before the sleep instruction, else no sleep.
// RL2 - Interrupt wake: halt core four cycles past start-up, then handler.
// RL3 - Register file and SRAM contents are never disturbed by sleep.
// RL4 - Reset during sleep wakes device and restarts at reset vector.
// RL5 - Software brown-out disable: off after entry, back on at every wake.
// RL6 - After brown-out-off sleep, wake-up takes about 60 us.
// RL7 - Brown-out sleep-off is bit 6, one disables, resets to zero.
// RL8 - Brown-out sleep-off writes only through a timed enable sequence.
// RL9 - Brown-out disable applies only in power-down, save, standby modes.
// RL10 - Mode 000 is idle: CPU and flash clocks stop, rest runs.
// RL11 - Idle or noise reduction with converter enabled starts a conversion.
// RL12 - Mode 001 noise reduction: I/O, CPU, flash clocks stop.
// RL13 - Noise reduction wakes only from its listed sources.
// RL14 - Mode 010 power-down: oscillator and all generated clocks stop.
// RL15 - Power-down wakes only from its listed asynchronous sources.
// RL16 - Level wake dropped before start-up ends wakes without interrupt.
// RL17 - Power-down wake delayed by fuse-defined start-up time.
// RL18 - Mode 011 power-save: like power-down, enabled Timer2 keeps counting.
// RL19 - Power-save Timer2 wake needs matching mask bit and global enable.
// RL20 - Power-save stops unused Timer2 oscillator or main clock source.
// RL21 - Software should prefer power-down when Timer2 is idle.
// RL22 - Modes 110 and 111 standby keep oscillator, wake in six cycles.
// RL23 - Mode select in bits 3:1, sleep arm in bit 0, reset zero.
// RL24 - Reserved codes 100 and 101 behave as idle.
// RL25 - Wake-up re-enables every clock and oscillator no later than the core resumes.
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH
`define SLP_SE_BIT 0
`define SLP_SM_LSB 1
`define SLP_SM_MSB 3
`define SLP_CTRL_RST 8'h00
`define SLP_BROWNOUT_SLEEP_OFF_BIT 6
`define SLP_BODSE_BIT 5
`define SLP_MCU_RST 8'h00
`define SLP_CLK_MHZ 40
`define SLP_HALT_CYC 4
`define SLP_STARTUP_CYC 16
`define SLP_STBY_CYC 6
`define SLP_BOD_WAKE_NS 60000
`define SLP_BOD_WAKE_CYC ((`SLP_BOD_WAKE_NS * `SLP_CLK_MHZ) / 1000)
`define SLP_BODSE_WIN 4
`endif

// ===== pkg/slp_pkg.sv
// Types for the sleep-mode clock gating controller.
// Assumes the defines header sits beside it.
package slp_pkg;
   typedef enum logic [2:0]
   {
      SLP_IDLE = 3'h0,
      SLP_ADCNR = 3'h1,
      SLP_PDOWN = 3'h2,
      SLP_PSAVE = 3'h3,
      SLP_RES4 = 3'h4,
      SLP_RES5 = 3'h5,
      SLP_STBY = 3'h6,
      SLP_XSTBY = 3'h7
   } slp_mode_t;
   typedef enum logic [3:0]
   {
      ST_RUN = 4'h1,
      ST_SLEEP = 4'h2,
      ST_START = 4'h4,
      ST_HALT = 4'h8
   } slp_state_t;
endpackage : slp_pkg

// ===== test/slp_ctrl_props.sv
// Port checker for the sleep controller, bound into slp_ctrl.
// Assumes the single mclk domain and synchronous reset rst_b.
`timescale 1ns/1ps
`default_nettype none
module slp_ctrl_props
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic sleepInstr,
   input wire logic adcEnabled,
   input wire logic [7:0] sleepCtrlRd,
   input wire logic cpuClkEn,
   input wire logic flashClkEn,
   input wire logic ioClkEn,
   input wire logic adcClkEn,
   input wire logic mainOscEn,
   input wire logic bodEn,
   input wire logic adcStart,
   input wire logic coreHalt,
   input wire logic irqDeliver,
   input wire logic resetVector,
   input wire logic sleeping
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   logic [2:0] md;
   assign md = sleepCtrlRd[3:1];
   chk_idle_gates: assert property ($rose(sleeping) && (md == 3'h0 || md[2:1] == 2'h2)
      |-> !cpuClkEn && !flashClkEn && ioClkEn && adcClkEn) else $error("idle gating");
   chk_noise_gates: assert property ($rose(sleeping) && md == 3'h1
      |-> !ioClkEn && !cpuClkEn && adcClkEn) else $error("noise gating");
   chk_pdown_gates: assert property ($rose(sleeping) && md == 3'h2
      |-> !mainOscEn && !adcClkEn && !ioClkEn) else $error("pdown gating");
   chk_stby_osc: assert property ($rose(sleeping) && md[2:1] == 2'h3
      |-> mainOscEn && !ioClkEn) else $error("standby osc");
   chk_bod_kept: assert property ($rose(sleeping) && md[2:1] == 2'h0 |-> bodEn)
      else $error("bod off in idle");
   chk_unarmed_stay: assert property (sleepInstr && !sleepCtrlRd[0] && !sleeping
      |=> !sleeping) else $error("slept unarmed");
   chk_wake_clocks: assert property ($fell(coreHalt) && !resetVector
      |-> cpuClkEn && flashClkEn && ioClkEn && mainOscEn && bodEn) else $error("wake clocks");
   chk_halt_four: assert property (irqDeliver
      |-> $fell(coreHalt) && $past(cpuClkEn, 4) && !$past(cpuClkEn, 5)) else $error("halt length");
   chk_adc_quiet: assert property (adcStart |-> $past(adcEnabled) && sleeping)
      else $error("adc start unasked");
   chk_reset_clear: assert property (resetVector |-> ##[0:2] sleepCtrlRd == 8'h00)
      else $error("reset wake clear");
   chk_adc_start: assert property (sleepInstr && sleepCtrlRd[0] && !sleeping
      && md[2:1] == 2'h0 && adcEnabled |-> ##[1:2] adcStart) else $error("adc start");
endmodule : slp_ctrl_props
bind slp_ctrl slp_ctrl_props u_props (.mclk, .rst_b, .sleepInstr, .adcEnabled, .sleepCtrlRd,
   .cpuClkEn, .flashClkEn, .ioClkEn, .adcClkEn, .mainOscEn, .bodEn, .adcStart, .coreHalt,
   .irqDeliver, .resetVector, .sleeping);
`default_nettype wire

// ===== test/slp_core_model.sv
// Core and level wake source beside the sleep controller.
// Assumes the bench arms sleep before asking for the instruction.
`timescale 1ns/1ps
`default_nettype none
module slp_core_model
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic goSleep,
   input wire logic goWake,
   input wire logic holdLvl,
   input wire logic irqDeliver,
   output logic sleepInstr,
   output logic extLevelIrq
);
   // A level dropped early still wakes, so without holdLvl it clears one cycle after rising instead of waiting for delivery
   always_ff @(posedge mclk)
   begin
      sleepInstr <= goSleep && rst_b;
      if (!rst_b || irqDeliver || (extLevelIrq && !holdLvl))
         extLevelIrq <= 1'b0;
      else if (goWake)
         extLevelIrq <= 1'b1;
   end
endmodule : slp_core_model
`default_nettype wire

// ===== test/tb_top.sv
// Scripted bench for the sleep controller.
// Assumes the core model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int SU = 16;
   localparam int BW = 40;
   logic mclk, rst_b, ctrlWrEn, mcuWrEn, goSleep, goWake, holdLvl, globalIrqEn;
   logic otherIoIrq, wakeReset, sleepInstr, extLevelIrq, cpuClkEn, flashClkEn, ioClkEn;
   logic adcClkEn, mainOscEn, bodEn, coreHalt, irqDeliver, resetVector, sleeping, adcStart;
   logic asyClkEn, timerOscEn, adcOn;
   logic [1:0] t2IrqMask, t2Event;
   logic [4:0] src;
   logic [6:0] en;
   logic [7:0] wd, sleepCtrlRd, mcuCtrlRd;
   int n_fail = 0;
   int check_count = 0;
   assign en = {irqDeliver, cpuClkEn, flashClkEn, ioClkEn, adcClkEn, mainOscEn, bodEn};
   slp_ctrl #(.STARTUP_CYC(SU), .BOD_WAKE_CYC(BW)) dut
   (
      .mclk, .rst_b, .ctrlWrEn, .ctrlWrData(wd), .mcuWrEn, .mcuWrData(wd), .sleepInstr,
      .extCrystal(1'b1), .adcEnabled(adcOn), .t2Enabled(1'b1), .t2Async(1'b0),
      .t2SyncClk(1'b0), .globalIrqEn, .t2IrqMask, .t2Event, .extLevelIrq,
      .pinChangeIrq(src[0]), .twoWireMatch(src[1]), .watchdogIrq(src[2]),
      .adcDoneIrq(src[3]), .selfProgReady(src[4]), .otherIoIrq, .wakeReset, .sleepCtrlRd,
      .mcuCtrlRd, .cpuClkEn, .flashClkEn, .ioClkEn, .adcClkEn, .asyClkEn, .mainOscEn,
      .timerOscEn, .bodEn, .adcStart, .coreHalt, .irqDeliver, .resetVector, .sleeping
   );
   slp_core_model core (.mclk, .rst_b, .goSleep, .goWake, .holdLvl, .irqDeliver,
      .sleepInstr, .extLevelIrq);
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : tk
   task automatic wr(input logic m);
      {ctrlWrEn, mcuWrEn} = {!m, m};
      tk(1);
      {ctrlWrEn, mcuWrEn} = 2'b00;
   endtask : wr
   task automatic brownout_sleep_off;
      mcuWrEn = 1'b1;
      wd = 8'h60;
      tk(1);
      wd = 8'h40;
      tk(1);
      mcuWrEn = 1'b0;
   endtask : brownout_sleep_off
   task automatic wslp(input logic v);
      for (int i = 0; i < 3000 && sleeping !== v; i++)
         tk(1);
      chk(sleeping, v);
   endtask : wslp
   task automatic issue(input logic [7:0] d);
      wd = d;
      wr(1'b0);
      tk(1);
      goSleep = 1'b1;
      tk(1);
      goSleep = 1'b0;
   endtask : issue
   task automatic slp(input logic [2:0] m);
      issue({4'h0, m, 1'b1});
      wslp(1'b1);
   endtask : slp
   // Counts wake-request to clocks-on, then clocks-on to core release
   task automatic wake(input logic hold, output int c, output int h);
      holdLvl = hold;
      goWake = 1'b1;
      tk(1);
      goWake = 1'b0;
      for (c = 0; cpuClkEn !== 1'b1 && c < 3000; c++)
         tk(1);
      for (h = 0; coreHalt !== 1'b0 && h < 20; h++)
         tk(1);
   endtask : wake
   task automatic t_modes;
      int c, h;
      logic [2:0] m;
      logic [4:0] e;
      for (int i = 0; i < 8; i++)
      begin
         m = i[2:0];
         e = m[2:1] == 2'h1 ? 5'h00 : m[2:1] == 2'h3 ? 5'h01 : m == 3'h1 ? 5'h03 : 5'h07;
         slp(m);
         chk(en[5:1], e);
         chk({asyClkEn, timerOscEn}, m[1] ? 2'h0 : m == 3'h1 ? 2'h2 : 2'h3);
         chk(adcStart, !m[1]);
         wake(1'b1, c, h);
         chk(c >= (m[2:1] == 2'h1 ? SU : m[2:1] == 2'h3 ? 6 : 1), 1'b1);
         chk(h, 4);
         chk(en, 7'h7f);
      end
      $display("done modes");
   endtask : t_modes
   task automatic t_bod;
      int c, h;
      wd = 8'h40;
      wr(1'b1);
      tk(6);
      chk(mcuCtrlRd[6], 1'b0);
      brownout_sleep_off();
      tk(1);
      chk(mcuCtrlRd[6], 1'b1);
      slp(3'h2);
      tk(1);
      chk(bodEn, 1'b0);
      wake(1'b1, c, h);
      chk(c >= BW, 1'b1);
      chk(bodEn, 1'b1);
      brownout_sleep_off();
      adcOn = 1'b0;
      slp(3'h0);
      chk(bodEn, 1'b1);
      chk(adcStart, 1'b0);
      adcOn = 1'b1;
      wake(1'b1, c, h);
      $display("done brownout");
   endtask : t_bod
   task automatic t_src;
      slp(3'h1);
      otherIoIrq = 1'b1;
      tk(SU + 20);
      chk(sleeping, 1'b1);
      otherIoIrq = 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         src[i] = 1'b1;
         wslp(1'b0);
         src = 5'h0;
         slp(i < 4 ? 3'h1 : 3'h3);
      end
      {t2IrqMask, t2Event} = 4'hf;
      tk(SU + 20);
      chk(sleeping, 1'b1);
      globalIrqEn = 1'b1;
      wslp(1'b0);
      $display("done wake sources");
   endtask : t_src
   task automatic t_rst;
      int c, h;
      slp(3'h2);
      tk(SU + 20);
      chk(sleeping, 1'b1);
      wake(1'b0, c, h);
      chk({irqDeliver, coreHalt}, 2'b00);
      slp(3'h2);
      wakeReset = 1'b1;
      for (c = 0; resetVector !== 1'b1 && c < 3000; c++)
         tk(1);
      chk(resetVector, 1'b1);
      wakeReset = 1'b0;
      tk(3);
      chk({sleepCtrlRd, sleeping, coreHalt}, 10'h0);
      $display("done reset wake");
   endtask : t_rst
   task automatic t_regs;
      chk({sleepCtrlRd, mcuCtrlRd, en[5:0]}, 22'h3f);
      wd = 8'hff;
      wr(1'b0);
      tk(1);
      chk(sleepCtrlRd, 8'h0f);
      issue(8'h04);
      tk(4);
      chk(sleeping, 1'b0);
      $display("done registers");
   endtask : t_regs
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      {rst_b, ctrlWrEn, mcuWrEn, goSleep, goWake, globalIrqEn, otherIoIrq, wakeReset} = '0;
      {t2IrqMask, t2Event, src, wd, holdLvl} = '0;
      adcOn = 1'b1;
      tk(5);
      rst_b = 1'b1;
      tk(1);
      t_regs();
      t_modes();
      t_bod();
      t_src();
      t_rst();
      tally_and_finish();
   end
   // Run needs well under the limit; a hang is cut short here
   initial
   begin
      #2000000;
      n_fail++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
